// ---- include/component_enable_defs.svh ----
`ifndef COMPONENT_ENABLE_DEFS_SVH
`define COMPONENT_ENABLE_DEFS_SVH

// ==========================================================
// Bitmap geometry
`define MAP_W 64
`define FEAT_NUM 8

// ==========================================================
// Component positions
`define BIT_FPU 0
`define BIT_SIMD 1
`define BIT_VEC256 2
`define BIT_BND_REGS 3
`define BIT_BND_CSR 4
`define BIT_OPMASK 5
`define BIT_VEC_HI 6
`define BIT_VEC_EXTRA 7
`define BIT_TRACE 8
`define BIT_PKEY 9
`define BIT_ASID 10
`define BIT_CF_USER 11
`define BIT_CF_SSP 12
`define BIT_DUTY 13
`define BIT_USER_INTERRUPT_STATE 14
`define BIT_BRANCH 15
`define BIT_PERF 16
`define BIT_TILE_CFG 17
`define BIT_TILE_DATA 18
`define BIT_SPECIAL 63

// ==========================================================
// Classification masks
`define USER_MASK 64'h0000_0000_0006_02ff
`define SUPV_MASK 64'h0000_0000_0001_fd00
`define RSVD_MASK 64'hffff_ffff_fff8_0000

// ==========================================================
// Register offsets and reset values
`define SUPV_ENABLE_OFFSET 12'hda0
`define USER_ENABLE_INDEX 12'h000
`define USER_ENABLE_RESET 64'h0000_0000_0000_0001
`define SUPV_ENABLE_RESET 64'h0000_0000_0000_0000

// ==========================================================
// Feature masks for enabling-dependent features
`define FEAT_VEC256_MASK 64'h0000_0000_0000_0006
`define FEAT_BOUNDS_MASK 64'h0000_0000_0000_0018
`define FEAT_WIDE_MASK 64'h0000_0000_0000_00e6
`define FEAT_TILE_MASK 64'h0000_0000_0006_0000

`endif

// ---- include/component_enable_pkg.sv ----
`default_nettype none

package component_enable_pkg;
	// Instruction family encodings
	typedef enum logic [2:0] {
		OP_PLAIN_SAVE = 3'h0,
		OP_COMPACT_SAVE = 3'h1,
		OP_OPT_SAVE = 3'h2,
		OP_PLAIN_RESTORE = 3'h3,
		OP_SUPV_SAVE = 3'h4,
		OP_SUPV_RESTORE = 3'h5
	} save_op_t;

	// Register write targets
	typedef enum logic [1:0] {
		TGT_NONE = 2'h0,
		TGT_USER = 2'h1,
		TGT_SUPV = 2'h2
	} reg_target_t;

	// Feature indices; all but FEAT_ALWAYS are enabling-dependent
	typedef enum logic [2:0] {
		FEAT_VEC256 = 3'h0,
		FEAT_BOUNDS = 3'h1,
		FEAT_WIDE = 3'h2,
		FEAT_TILE = 3'h3,
		FEAT_ALWAYS = 3'h4
	} feature_t;
endpackage

`default_nettype wire

// ---- rtl/component_mask_gate.sv ----
`default_nettype none
`include "component_enable_defs.svh"

// Combinational gate: turns an instruction mask into the set acted on
module component_mask_gate (
	// Request
	input wire logic [`MAP_W-1:0] instr_mask_in,
	input wire logic supervisor_op_in,
	// Enables
	input wire logic [`MAP_W-1:0] user_enable_in,
	input wire logic [`MAP_W-1:0] supv_enable_in,
	input wire logic os_save_enable_bit_in,
	// Result
	output logic [`MAP_W-1:0] effective_out
);
	logic [`MAP_W-1:0] user_part;
	logic [`MAP_W-1:0] supv_part;

	// User part only ever covers user components; bit 63 never maps
	assign user_part = instr_mask_in & user_enable_in
		& `USER_MASK;
	// Supervisor part only for supervisor save/restore
	assign supv_part = supervisor_op_in ?
		(instr_mask_in & supv_enable_in & `SUPV_MASK) :
		'0;

	// Nothing happens with the feature set switched off
	assign effective_out = os_save_enable_bit_in ?
		(user_part | supv_part) : '0;
endmodule

`default_nettype wire

// ---- rtl/state_component_enable_logic.sv ----
`default_nettype none
`include "component_enable_defs.svh"

// What this block does
// - Bitmaps are 64 bits, one bit per component
// - Bits 0,1,2: float, SIMD, 256-bit vector
// - Bits 4:3: bounds registers and bounds config
// - Bits 7:5: opmask, vector upper, extra vectors
// - Bits 8,9,10: trace, key rights, address ID
// - Bits 12:11: control-flow user and shadow pointers
// - Bits 13-16: duty, user interrupt, branch, perf
// - Bits 18:17: tile configuration and tile data
// - Bits 62:19 reserved, bit 63 no component
// - Instruction mask is high:low register concatenation
// - Classify user and supervisor component bits
// - Supervisor components only by supervisor save/restore
// - Clear user enable bit skips the component
// - Clear supervisor enable bit skips the component
// - Block writes to disabled enabling-dependent state
// - Clearing enable keeps component contents unchanged
// - Partially enabled feature raises invalid opcode
// - Save-enable bit low disables all dependent features
// - Non-dependent features always usable and writable
// - User enable bit 0 always one, clear faults
// - Only supported bits may be set
module state_component_enable_logic #(
	parameter logic [`MAP_W-1:0] USER_SUPPORTED = `USER_MASK,
	parameter logic [`MAP_W-1:0] SUPV_SUPPORTED = `SUPV_MASK
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Control register enable
	input wire logic os_save_enable_bit_in,
	// Enable register writes
	input wire logic reg_write_in,
	input wire component_enable_pkg::reg_target_t reg_target_in,
	input wire logic [31:0] write_high_in,
	input wire logic [31:0] write_low_in,
	// Save/restore instruction issue
	input wire logic op_valid_in,
	input wire component_enable_pkg::save_op_t op_kind_in,
	input wire logic [31:0] mask_high_in,
	input wire logic [31:0] mask_low_in,
	// Feature instruction and state-write checks
	input wire logic feat_check_in,
	input wire component_enable_pkg::feature_t feat_sel_in,
	input wire logic [`MAP_W-1:0] state_write_req_in,
	// Register contents
	output logic [`MAP_W-1:0] user_enable_register_out,
	output logic [`MAP_W-1:0] supervisor_enable_register_out,
	// Results
	output logic [`MAP_W-1:0] effective_set_out,
	output logic effective_valid_out,
	output logic [`MAP_W-1:0] state_write_allow_out,
	output logic invalid_opcode_fault_out,
	output logic general_protection_fault_out
);
	import component_enable_pkg::*;

	// ==========================================================
	// Component table
	logic [`MAP_W-1:0] user_class;
	logic [`MAP_W-1:0] supv_class;
	logic [`MAP_W-1:0] dependent_bits;

	// One entry per defined component. Bits 62:19 stay unmapped
	// and bit 63 never names a component, so all three maps are
	// zero there and nothing can ever select them. Class and
	// enabling need are kept apart: the SIMD component is a user
	// component whose feature still runs with no enable at all.
	always_comb begin
		user_class = '0;
		supv_class = '0;
		dependent_bits = '0;
		// Legacy floating-point state: usable without enabling
		user_class[`BIT_FPU] = 1'b1;
		// 128-bit SIMD state: its instructions run regardless
		user_class[`BIT_SIMD] = 1'b1;
		// 256-bit vector state
		user_class[`BIT_VEC256] = 1'b1;
		dependent_bits[`BIT_VEC256] = 1'b1;
		// Bounds registers
		user_class[`BIT_BND_REGS] = 1'b1;
		dependent_bits[`BIT_BND_REGS] = 1'b1;
		// Bounds configuration and status
		user_class[`BIT_BND_CSR] = 1'b1;
		dependent_bits[`BIT_BND_CSR] = 1'b1;
		// Opmask registers
		user_class[`BIT_OPMASK] = 1'b1;
		dependent_bits[`BIT_OPMASK] = 1'b1;
		// Upper halves of the low vector registers
		user_class[`BIT_VEC_HI] = 1'b1;
		dependent_bits[`BIT_VEC_HI] = 1'b1;
		// Extra full-width vector registers
		user_class[`BIT_VEC_EXTRA] = 1'b1;
		dependent_bits[`BIT_VEC_EXTRA] = 1'b1;
		// Trace-facility registers
		supv_class[`BIT_TRACE] = 1'b1;
		// Protection-key rights register
		user_class[`BIT_PKEY] = 1'b1;
		// Address space identifier register
		supv_class[`BIT_ASID] = 1'b1;
		// Control-flow user registers
		supv_class[`BIT_CF_USER] = 1'b1;
		// Shadow-stack pointers
		supv_class[`BIT_CF_SSP] = 1'b1;
		// Duty-cycling control
		supv_class[`BIT_DUTY] = 1'b1;
		// User-interrupt state
		supv_class[`BIT_USER_INTERRUPT_STATE] = 1'b1;
		// Branch-record configuration
		supv_class[`BIT_BRANCH] = 1'b1;
		// Performance-state control
		supv_class[`BIT_PERF] = 1'b1;
		// Tile configuration
		user_class[`BIT_TILE_CFG] = 1'b1;
		dependent_bits[`BIT_TILE_CFG] = 1'b1;
		// Tile contents
		user_class[`BIT_TILE_DATA] = 1'b1;
		dependent_bits[`BIT_TILE_DATA] = 1'b1;
		// Special-function bit: never a component in any map
		user_class[`BIT_SPECIAL] = 1'b0;
	end

	// ==========================================================
	// Enable registers
	logic [`MAP_W-1:0] user_enable_reg;
	logic [`MAP_W-1:0] supv_enable_reg;
	logic [`MAP_W-1:0] write_value;
	logic [`MAP_W-1:0] user_legal;
	logic [`MAP_W-1:0] supv_legal;
	logic user_write_off;
	logic user_write_base;
	logic user_write_unsup;
	logic user_write_hit;
	logic supv_write_hit;
	logic user_write_bad;
	logic supv_write_bad;

	// Written value comes from the high:low register pair; the
	// low word lands in bits 31:0
	assign write_value = {write_high_in, write_low_in};

	// Supported bits, limited to the class each register manages;
	// a parameter that over-claims cannot open a supervisor bit
	// in the user register or the other way round
	assign user_legal = USER_SUPPORTED & user_class;
	assign supv_legal = SUPV_SUPPORTED & supv_class;

	// A user write is refused while the feature set is off
	assign user_write_off = !os_save_enable_bit_in;
	// Bit 0 may never go low
	assign user_write_base = !write_value[`BIT_FPU];
	// No bit outside support may go high
	assign user_write_unsup = |(write_value & ~user_legal);
	assign user_write_bad = user_write_off || user_write_base
		|| user_write_unsup;
	assign supv_write_bad = |(write_value & ~supv_legal);

	// ==========================================================
	// Register write decode
	assign user_write_hit = reg_write_in && reg_target_in == TGT_USER;
	assign supv_write_hit = reg_write_in && reg_target_in == TGT_SUPV;

	// User enable register; a clear only drops the enable, the
	// component's own registers live elsewhere and are not touched
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			user_enable_reg <= `USER_ENABLE_RESET;
		end else if (user_write_hit && !user_write_bad) begin
			user_enable_reg <= write_value;
		end
	end

	// Supervisor enable register; resets all clear and a good
	// write lands whole, a refused one leaves it untouched
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			supv_enable_reg <= `SUPV_ENABLE_RESET;
		end else if (supv_write_hit && !supv_write_bad) begin
			supv_enable_reg <= write_value;
		end
	end

	assign user_enable_register_out = user_enable_reg;
	assign supervisor_enable_register_out = supv_enable_reg;

	// ==========================================================
	// Instruction mask gating
	logic [`MAP_W-1:0] instr_mask;
	logic supervisor_op;
	logic [`MAP_W-1:0] gated_set;

	assign instr_mask = {mask_high_in, mask_low_in};

	// Only the two supervisor instructions reach supervisor state;
	// the four other kinds see user components alone
	always_comb begin
		unique case (op_kind_in)
			// Plain, compacted and optimized saves
			OP_PLAIN_SAVE: supervisor_op = 1'b0;
			OP_COMPACT_SAVE: supervisor_op = 1'b0;
			OP_OPT_SAVE: supervisor_op = 1'b0;
			// Plain restore
			OP_PLAIN_RESTORE: supervisor_op = 1'b0;
			// Supervisor save and restore
			OP_SUPV_SAVE: supervisor_op = 1'b1;
			OP_SUPV_RESTORE: supervisor_op = 1'b1;
			// Codes 6 and 7 name no instruction: safest as user kind
			default: supervisor_op = 1'b0;
		endcase
	end

	// The gate is pure logic; the result is registered below so
	// the enables and mask seen by a save/restore are those of
	// the issue cycle, not of a write landing on the same edge
	component_mask_gate u_gate (
		.instr_mask_in(instr_mask),
		.supervisor_op_in(supervisor_op),
		.user_enable_in(user_enable_reg),
		.supv_enable_in(supv_enable_reg),
		.os_save_enable_bit_in(os_save_enable_bit_in),
		.effective_out(gated_set)
	);

	// Valid pulse follows every issue, refused ones too, so the
	// core always gets an answer one cycle later
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			effective_valid_out <= 1'b0;
		end else begin
			effective_valid_out <= op_valid_in;
		end
	end

	// Set holds between issues so a late reader still sees it
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			effective_set_out <= '0;
		end else if (op_valid_in) begin
			effective_set_out <= gated_set;
		end
	end

	// ==========================================================
	// Feature enable checks
	logic [`MAP_W-1:0] live_user_enable;
	logic [`MAP_W-1:0] feat_mask;

	// Save-enable low looks like an all-clear user register; the
	// register itself keeps its value so state comes back intact
	// once the feature set is switched on again
	assign live_user_enable = os_save_enable_bit_in ?
		user_enable_reg : '0;

	// Component set each feature needs; a feature counts as
	// enabled only when every one of its components is
	always_comb begin
		feat_mask = '0;
		unique case (feat_sel_in)
			FEAT_VEC256: begin
				// 256-bit vectors build on the SIMD state
				feat_mask[`BIT_SIMD] = 1'b1;
				feat_mask[`BIT_VEC256] = 1'b1;
			end
			FEAT_BOUNDS: begin
				feat_mask[`BIT_BND_REGS] = 1'b1;
				feat_mask[`BIT_BND_CSR] = 1'b1;
			end
			FEAT_WIDE: begin
				// Wide vectors also need the narrower vector state
				feat_mask[`BIT_SIMD] = 1'b1;
				feat_mask[`BIT_VEC256] = 1'b1;
				feat_mask[`BIT_OPMASK] = 1'b1;
				feat_mask[`BIT_VEC_HI] = 1'b1;
				feat_mask[`BIT_VEC_EXTRA] = 1'b1;
			end
			FEAT_TILE: begin
				feat_mask[`BIT_TILE_CFG] = 1'b1;
				feat_mask[`BIT_TILE_DATA] = 1'b1;
			end
			// Non-dependent features never fault on enables
			FEAT_ALWAYS: feat_mask = '0;
			// Codes 5 to 7 name no feature
			default: feat_mask = '0;
		endcase
	end

	// Per-component write permission: dependent components need
	// their enable; all others stay modifiable at all times.
	// This only gates requests: a blocked write leaves the state
	// as it was, it never clears it
	genvar g;
	generate
		for (g = 0; g < `MAP_W; g++) begin : g_allow
			assign state_write_allow_out[g] = state_write_req_in[g]
				&& (!dependent_bits[g]
				|| live_user_enable[g]);
		end
	endgenerate

	// ==========================================================
	// Fault flags
	logic feat_missing;
	logic op_refused;
	logic write_refused;

	// A feature faults when any needed component is not live
	assign feat_missing = feat_check_in
		&& ((feat_mask & ~live_user_enable) != '0);
	// Save/restore with the feature set off never executes
	assign op_refused = op_valid_in
		&& !os_save_enable_bit_in;
	// Refused writes leave the register as it was
	assign write_refused = (user_write_hit && user_write_bad)
		|| (supv_write_hit && supv_write_bad);

	// Invalid-opcode flag, a one-cycle pulse
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			invalid_opcode_fault_out <= 1'b0;
		end else begin
			invalid_opcode_fault_out <= feat_missing || op_refused;
		end
	end

	// General-protection flag, a one-cycle pulse; the core turns
	// it into the fault, this block only reports the refusal
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			general_protection_fault_out <= 1'b0;
		end else begin
			general_protection_fault_out <= write_refused;
		end
	end
endmodule

`default_nettype wire

// ---- sim/state_component_enable_checker.sv ----
`default_nettype none
`include "component_enable_defs.svh"

module state_component_enable_checker import component_enable_pkg::*; #(
	parameter logic [`MAP_W-1:0] USER_SUPPORTED = `USER_MASK,
	parameter logic [`MAP_W-1:0] SUPV_SUPPORTED = `SUPV_MASK
) (
	input wire logic clk_in, rst_n_in, os_save_enable_bit_in,
	input wire logic reg_write_in, op_valid_in,
	input wire reg_target_t reg_target_in,
	input wire save_op_t op_kind_in,
	input wire logic [31:0] write_high_in, write_low_in,
	input wire logic [31:0] mask_high_in, mask_low_in,
	input wire logic [`MAP_W-1:0] user_enable_register_out,
	input wire logic [`MAP_W-1:0] supervisor_enable_register_out,
	input wire logic [`MAP_W-1:0] effective_set_out, state_write_allow_out,
	input wire logic effective_valid_out, invalid_opcode_fault_out,
	input wire logic general_protection_fault_out
);
	// ==========
	// Expected set, taken one cycle later through $past
	logic [`MAP_W-1:0] mask_w, wr_w, exp_set;
	logic os_on, supv_op;
	assign mask_w = {mask_high_in, mask_low_in};
	assign wr_w = {write_high_in, write_low_in};
	assign os_on = os_save_enable_bit_in;
	assign supv_op = op_kind_in inside {OP_SUPV_SAVE, OP_SUPV_RESTORE};
	assign exp_set = (mask_w & user_enable_register_out & `USER_MASK) |
		(supv_op ? mask_w & supervisor_enable_register_out & `SUPV_MASK : '0);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	// ==========
	// Properties
	valid_pulse_a: assert property (op_valid_in |=> effective_valid_out)
		else $error("valid missing");
	gated_set_a: assert property (op_valid_in && os_on |=>
		effective_set_out == $past(exp_set)) else $error("set wrong");
	rsvd_zero_a: assert property (effective_valid_out |->
		(effective_set_out & `RSVD_MASK) == '0) else $error("reserved set");
	os_off_a: assert property (op_valid_in && !os_on |=>
		effective_set_out == '0 && invalid_opcode_fault_out) else $error("os off");
	base_bit_a: assert property (user_enable_register_out[0])
		else $error("bit0 clear");
	clear_base_a: assert property (reg_write_in && reg_target_in == TGT_USER &&
		!wr_w[0] |=> general_protection_fault_out &&
		$stable(user_enable_register_out)) else $error("bit0 write taken");
	supv_unsup_a: assert property (reg_write_in && reg_target_in == TGT_SUPV &&
		|(wr_w & ~SUPV_SUPPORTED) |=> general_protection_fault_out &&
		$stable(supervisor_enable_register_out)) else $error("bad supv write");
	dep_block_a: assert property (!os_on |->
		(state_write_allow_out & 64'h6_00fc) == '0) else $error("write allowed");
	cover property (op_valid_in && supv_op && os_on);
	cover property (general_protection_fault_out);
	cover property (invalid_opcode_fault_out);
endmodule

bind state_component_enable_logic state_component_enable_checker #(
	.USER_SUPPORTED(USER_SUPPORTED), .SUPV_SUPPORTED(SUPV_SUPPORTED)
) state_component_enable_checker_i (
	.clk_in(clk_in), .rst_n_in(rst_n_in),
	.os_save_enable_bit_in(os_save_enable_bit_in),
	.reg_write_in(reg_write_in), .op_valid_in(op_valid_in),
	.reg_target_in(reg_target_in), .op_kind_in(op_kind_in),
	.write_high_in(write_high_in), .write_low_in(write_low_in),
	.mask_high_in(mask_high_in), .mask_low_in(mask_low_in),
	.user_enable_register_out(user_enable_register_out),
	.supervisor_enable_register_out(supervisor_enable_register_out),
	.effective_set_out(effective_set_out),
	.state_write_allow_out(state_write_allow_out),
	.effective_valid_out(effective_valid_out),
	.invalid_opcode_fault_out(invalid_opcode_fault_out),
	.general_protection_fault_out(general_protection_fault_out));

`default_nettype wire

// ---- sim/state_component_enable_logic_tb.sv ----
`default_nettype none
`include "component_enable_defs.svh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin error_cnt++; \
	$display("mismatch %s exp %h got %h", n, e, s); end end

module state_component_enable_logic_tb import component_enable_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========
	// Stimulus, outputs and the bench copy of both registers
	logic clk_in = 0, rst_n_in = 0, os = 0, wr = 0, opv = 0, fc = 0;
	reg_target_t tgt = TGT_NONE;
	save_op_t kind = OP_PLAIN_SAVE;
	feature_t fs = FEAT_VEC256;
	logic [63:0] wv = '0, mv = '0, req = '0, ue_m = 64'h1, se_m = '0;
	logic [63:0] ue, se, es, al, r, w;
	logic ev, iof, gpf;
	int error_cnt = 0, checked = 0, seed = 32'h3f693d6e, k;
	state_component_enable_logic state_component_enable_logic_i (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .os_save_enable_bit_in(os),
		.reg_write_in(wr), .reg_target_in(tgt), .write_high_in(wv[63:32]),
		.write_low_in(wv[31:0]), .op_valid_in(opv), .op_kind_in(kind),
		.mask_high_in(mv[63:32]), .mask_low_in(mv[31:0]), .feat_check_in(fc),
		.feat_sel_in(fs), .state_write_req_in(req),
		.user_enable_register_out(ue), .supervisor_enable_register_out(se),
		.effective_set_out(es), .effective_valid_out(ev),
		.state_write_allow_out(al), .invalid_opcode_fault_out(iof),
		.general_protection_fault_out(gpf));
	// 100 MHz clock
	always #5 clk_in = ~clk_in;
	// Components each feature needs enabled
	function automatic logic [63:0] need(feature_t f);
		case (f)
			FEAT_VEC256: return `FEAT_VEC256_MASK;
			FEAT_BOUNDS: return `FEAT_BOUNDS_MASK;
			FEAT_WIDE: return `FEAT_WIDE_MASK;
			FEAT_TILE: return `FEAT_TILE_MASK;
			default: return '0;
		endcase
	endfunction
	// Verdict; the watchdog ends here too
	task automatic complete_run();
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// One transfer; pulses are checked low first, so each stands one cycle
	task automatic txn(int k, logic [63:0] w, m, r, logic o, save_op_t s,
		feature_t f);
		logic ok, ud;
		logic [63:0] ex;
		@(posedge clk_in);
		wr <= k < 2;
		tgt <= k == 0 ? TGT_USER : (k == 1 ? TGT_SUPV : TGT_NONE);
		opv <= k == 2;
		fc <= k == 3;
		wv <= w;
		mv <= m;
		req <= r;
		os <= o;
		kind <= s;
		fs <= f;
		#1;
		`CHK("pulses", 3'b000, {ev, iof, gpf})
		`CHK("allow", r & ~(64'h6_00fc & ~(o ? ue_m : '0)), al)
		ok = k == 0 ? w[0] && o && !(w & ~`USER_MASK) : !(w & ~`SUPV_MASK);
		ex = (m & ue_m & `USER_MASK) |
			(s > OP_PLAIN_RESTORE ? m & se_m & `SUPV_MASK : '0);
		ud = k == 2 ? !o : k == 3 && f != FEAT_ALWAYS &&
			(!o || (ue_m & need(f)) != need(f));
		if (k == 0 && ok) ue_m = w;
		if (k == 1 && ok) se_m = w;
		@(posedge clk_in);
		wr <= 0;
		opv <= 0;
		fc <= 0;
		#1;
		`CHK("gp", k < 2 && !ok, gpf)
		`CHK("ud", ud, iof)
		`CHK("valid", k == 2, ev)
		`CHK("user", ue_m, ue)
		`CHK("supv", se_m, se)
		if (k == 2) `CHK("set", o ? ex : '0, es)
	endtask
	// Corner cases first, then random traffic
	initial begin
		repeat (16) @(posedge clk_in);
		rst_n_in <= 1;
		txn(0, 64'h6, '0, '1, 1, OP_PLAIN_SAVE, FEAT_VEC256);
		txn(0, 64'h8000_0000_0000_0001, '0, '1, 1, OP_PLAIN_SAVE, FEAT_TILE);
		txn(0, 64'h7, '0, '1, 0, OP_PLAIN_SAVE, FEAT_VEC256);
		txn(0, `USER_MASK, '0, '1, 1, OP_PLAIN_SAVE, FEAT_VEC256);
		txn(1, 64'h200, '0, '1, 1, OP_PLAIN_SAVE, FEAT_VEC256);
		txn(1, `SUPV_MASK, '0, '1, 1, OP_PLAIN_SAVE, FEAT_VEC256);
		for (int i = 0; i < 6; i++) begin
			txn(2, '0, '1, '1, 1, save_op_t'(i), FEAT_VEC256);
		end
		txn(2, '0, '1, '1, 0, OP_SUPV_SAVE, FEAT_VEC256);
		for (int i = 0; i < 10; i++) begin
			if (i == 5) txn(0, 64'h3, '0, '1, 1, OP_PLAIN_SAVE, FEAT_VEC256);
			txn(3, '0, '0, '1, 1, OP_PLAIN_SAVE, feature_t'(i % 5));
		end
		repeat (2000) begin
			r = {$random(seed), $random(seed)};
			k = $unsigned($random(seed)) % 4;
			w = r & (r[63] ? '1 : (k == 0 ? `USER_MASK : `SUPV_MASK));
			w[0] = w[0] | (k == 0 && r[62]);
			txn(k, w, {r[31:0], r[63:32]}, r, r[60:58] != 0,
				save_op_t'(r[57:55] % 6), feature_t'(r[54:52] % 5));
		end
		complete_run();
	end
	// Watchdog at nearly four times the expected run
	initial begin
		#150000;
		error_cnt++;
		complete_run();
	end
endmodule

`default_nettype wire
